// *** src/station_mgmt_phy_select.v ***
// Purpose: Station management unit and media interface selection
// Assumes: 50 MHz clk, sync active-low reset, straps static after reset
// Notes:   MAC role drives MDC/MDIO; PHY role answers an external MAC
`timescale 1ns/1ps
`include "station_mgmt_regs.vh"

module station_mgmt_phy_select (
  input  wire        clk,
  input  wire        rstn,
  input  wire        strap_rmii_n,
  input  wire        strap_phy_n,
  input  wire [4:0]  secondary_phy_address,
  input  wire        sw_iface_sel,
  input  wire        ref_clock_direction_flag,
  input  wire        link_up,
  input  wire        cmd_start,
  input  wire        cmd_read,
  input  wire [4:0]  cmd_phy_addr,
  input  wire [4:0]  cmd_reg_addr,
  input  wire [15:0] cmd_wdata,
  output reg         cmd_busy,
  output reg         cmd_done,
  output reg  [15:0] cmd_rdata,
  input  wire        mdc_in,
  output reg         mdc_out,
  output reg         mdc_oe,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe,
  output reg         emb_mdc,
  output reg         emb_mdio_in,
  input  wire        emb_mdio_out,
  output reg         mac_mode,
  output reg         datapath_to_ext,
  output reg         rmii_ref_clock_out_oe,
  output reg  [4:0]  ext_media_addr
);

  // ************************************************************
  // Pin synchronisers and strap capture
  // ************************************************************
  wire [3:0] pins_s;
  reg  [2:0] settle;
  reg        strap_done;
  reg        ext_iface;

  pin_sync3 #(.W(4), .RST(4'h7)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .pin_in   ({mdc_in, mdio_in, strap_rmii_n, strap_phy_n}),
    .sync_out (pins_s)
  );

  wire mdc_s   = pins_s[3];
  wire mdio_s  = pins_s[2];
  wire phy_sel = ~pins_s[1] & ~pins_s[0];

  // Straps taken once after the synchronisers have settled
  always @(posedge clk) begin
    if (!rstn) begin
      settle     <= 3'h0;
      strap_done <= 1'b0;
      mac_mode   <= 1'b1;
      ext_iface  <= 1'b0;
    end else if (!strap_done) begin
      // Filter output only settles on the fourth edge; take it on the fifth
      settle <= settle + 3'h1;
      if (settle == `STRAP_SETTLE) begin
        strap_done <= 1'b1;
        mac_mode   <= ~phy_sel;
        ext_iface  <= ~pins_s[1];
      end
    end
  end

  // Datapath routing, reference clock direction and external address
  always @(posedge clk) begin
    if (!rstn) begin
      datapath_to_ext       <= 1'b0;
      rmii_ref_clock_out_oe <= 1'b0;
      ext_media_addr        <= 5'h00;
    end else begin
      datapath_to_ext <= mac_mode & ext_iface & sw_iface_sel;
      // Pad takes the 100 MHz PLL divided by two; we only gate it
      rmii_ref_clock_out_oe <= ext_iface & ref_clock_direction_flag;
      if (mac_mode)
        ext_media_addr <= secondary_phy_address;
      else
        ext_media_addr <= {secondary_phy_address[4:1], 1'b0};
    end
  end

  // ************************************************************
  // MAC role: management controller
  // ************************************************************
  reg [63:0] frame;
  reg [6:0]  bit_cnt;
  reg [7:0]  div;
  reg        m_read;
  reg        m_emb;

  // Read data mux: embedded PHY only when addressed
  wire mdin = m_emb ? emb_mdio_out : mdio_s;
  wire tick = (div == `MDC_HALF_CYC - 1);

  // ************************************************************
  // PHY role: frame decoder state
  // ************************************************************
  localparam S_IDLE = 5'h01;
  localparam S_HDR  = 5'h02;
  localparam S_TA   = 5'h04;
  localparam S_RDAT = 5'h08;
  localparam S_WDAT = 5'h10;

  reg [4:0]  st;
  reg [5:0]  pre_cnt;
  reg        st0;
  reg [11:0] hdr;
  reg [4:0]  cnt;
  reg [15:0] sh;
  reg [15:0] ctrl;
  reg        mdc_q;
  reg        s_ext;
  reg        s_emb;
  reg        s_rd;

  wire rise = mdc_s & ~mdc_q;
  wire fall = ~mdc_s & mdc_q;

  // Emulated register contents; status shows live link
  function [15:0] phy_reg;
    input [4:0]  ra;
    input [15:0] c;
    input        lk;
    begin
      case (ra)
        `REG_CTRL:   phy_reg = c;
        `REG_STATUS: phy_reg = `STATUS_BASE | ({15'h0, lk} << `LINK_BIT);
        `REG_ID1:    phy_reg = `ID1_VALUE;
        `REG_ID2:    phy_reg = `ID2_VALUE;
        default:     phy_reg = 16'h0000;
      endcase
    end
  endfunction

  // Both roles share the pin flops; mode picks who owns them
  always @(posedge clk) begin
    if (!rstn) begin
      frame       <= 64'h0;
      bit_cnt     <= 7'h0;
      div         <= 8'h0;
      m_read      <= 1'b0;
      m_emb       <= 1'b0;
      cmd_busy    <= 1'b0;
      cmd_done    <= 1'b0;
      cmd_rdata   <= 16'h0;
      mdc_out     <= 1'b0;
      mdc_oe      <= 1'b0;
      mdio_out    <= 1'b1;
      mdio_oe     <= 1'b0;
      emb_mdc     <= 1'b0;
      emb_mdio_in <= 1'b1;
      st          <= S_IDLE;
      pre_cnt     <= 6'h0;
      st0         <= 1'b0;
      hdr         <= 12'h0;
      cnt         <= 5'h0;
      sh          <= 16'h0;
      ctrl        <= `CTRL_RST;
      mdc_q       <= 1'b0;
      s_ext       <= 1'b0;
      s_emb       <= 1'b0;
      s_rd        <= 1'b0;
    end else if (mac_mode) begin
      cmd_done <= 1'b0;
      mdc_oe   <= strap_done;
      emb_mdc  <= mdc_out;
      emb_mdio_in <= mdio_oe ? mdio_out : 1'b1;
      if (!cmd_busy) begin
        div <= 8'h0;
        if (cmd_start && strap_done) begin
          // Preamble, start, opcode, address, register, turnaround, data
          frame <= {32'hffffffff, 2'b01,
                    cmd_read ? `OP_READ : `OP_WRITE,
                    cmd_phy_addr, cmd_reg_addr,
                    cmd_read ? 2'b00 : 2'b10, cmd_wdata};
          m_read   <= cmd_read;
          m_emb    <= (cmd_phy_addr == `EMB_PHY_ADDR);
          bit_cnt  <= 7'h0;
          cmd_busy <= 1'b1;
          mdio_oe  <= 1'b1;
          mdio_out <= 1'b1;
          mdc_out  <= 1'b0;
        end
      end else if (!tick) begin
        div <= div + 8'h1;
      end else begin
        div <= 8'h0;
        if (!mdc_out) begin
          // Rising edge: far end samples, we capture read data
          mdc_out <= 1'b1;
          if (m_read && bit_cnt >= `DATA_BIT)
            cmd_rdata <= {cmd_rdata[14:0], mdin};
        end else begin
          mdc_out <= 1'b0;
          if (bit_cnt == `LAST_BIT) begin
            cmd_busy <= 1'b0;
            cmd_done <= 1'b1;
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b1;
          end else begin
            bit_cnt  <= bit_cnt + 7'h1;
            frame    <= {frame[62:0], 1'b0};
            mdio_out <= frame[62];
            // Release the line for the answer of a read
            mdio_oe  <= ~(m_read && (bit_cnt + 7'h1 >= `TA_BIT));
          end
        end
      end
    end else begin
      // PHY role: MDC is an input from the external MAC
      mdc_oe      <= 1'b0;
      mdc_out     <= 1'b0;
      cmd_busy    <= 1'b0;
      cmd_done    <= cmd_start;
      mdc_q       <= mdc_s;
      emb_mdc     <= mdc_s;
      emb_mdio_in <= mdio_s;
      case (st)
        S_IDLE: begin
          if (rise) begin
            if (mdio_s) begin
              if (st0) begin
                st  <= S_HDR;
                cnt <= 5'h0;
                st0 <= 1'b0;
              end else if (pre_cnt != `PRE_BITS) begin
                pre_cnt <= pre_cnt + 6'h1;
              end
            end else begin
              st0     <= (pre_cnt == `PRE_BITS) && !st0;
              pre_cnt <= 6'h0;
            end
          end
        end
        S_HDR: begin
          if (rise) begin
            hdr <= {hdr[10:0], mdio_s};
            cnt <= cnt + 5'h1;
            if (cnt == 5'd11) begin
              st    <= S_TA;
              cnt   <= 5'h0;
              s_rd  <= (hdr[10:9] == `OP_READ);
              s_ext <= (hdr[8:4] == ext_media_addr);
              s_emb <= (hdr[8:4] == `EMB_PHY_ADDR);
              sh    <= phy_reg({hdr[3:0], mdio_s}, ctrl, link_up);
            end
          end
        end
        S_TA: begin
          // Second turnaround bit driven low by the answering PHY
          if (fall && cnt == 5'h1 && s_rd && (s_ext || s_emb)) begin
            mdio_oe  <= 1'b1;
            mdio_out <= s_emb ? emb_mdio_out : 1'b0;
          end
          if (rise) begin
            cnt <= cnt + 5'h1;
            if (cnt == 5'h1) begin
              st  <= s_rd ? S_RDAT : S_WDAT;
              cnt <= 5'h0;
            end
          end
        end
        S_RDAT: begin
          if (fall) begin
            cnt <= cnt + 5'h1;
            if (cnt == 5'd16) begin
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b1;
              st       <= S_IDLE;
            end else begin
              mdio_out <= s_emb ? emb_mdio_out : sh[15];
              sh       <= {sh[14:0], 1'b0};
            end
          end else if (s_emb && mdio_oe) begin
            mdio_out <= emb_mdio_out;
          end
        end
        S_WDAT: begin
          if (rise) begin
            sh  <= {sh[14:0], mdio_s};
            cnt <= cnt + 5'h1;
            if (cnt == 5'd15) begin
              st <= S_IDLE;
              if (s_ext && hdr[4:0] == `REG_CTRL)
                ctrl <= {sh[14:0], mdio_s};
            end
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

endmodule

// *** src/station_mgmt_regs.vh ***
// Purpose: Constants shared by the station management / PHY select block
// Assumes: 50 MHz core clock, one clock domain
// Notes:   Definitions only; included by bare name
`ifndef STATION_MGMT_REGS_VH
`define STATION_MGMT_REGS_VH

// ************************************************************
// Addresses and frame layout
// ************************************************************
`define EMB_PHY_ADDR      5'h10
`define OP_READ           2'h2
`define OP_WRITE          2'h1
`define PRE_BITS          6'h20
`define TA_BIT            7'h2e
`define DATA_BIT          7'h30
`define LAST_BIT          7'h3f

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS     20
`define MDC_HALF_NS       200
`define MDC_HALF_CYC      ((`MDC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE      3'h4

// ************************************************************
// Emulated PHY register file (PHY role)
// ************************************************************
`define REG_CTRL          5'h00
`define REG_STATUS        5'h01
`define REG_ID1           5'h02
`define REG_ID2           5'h03
`define CTRL_RST          16'h3100
`define STATUS_BASE       16'h7809
`define LINK_BIT          2
// Identity words are arbitrary neutral values
`define ID1_VALUE         16'h1234
`define ID2_VALUE         16'h5670

`endif

// *** src/pin_sync3.v ***
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   Output moves only when second and third stages agree
`timescale 1ns/1ps

module pin_sync3 #(
  parameter       W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // First stage feeds only the second; filter looks at stages two and three
  always @(posedge clk) begin
    if (!rstn) begin
      s1       <= RST;
      s2       <= RST;
      s3       <= RST;
      sync_out <= RST;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        sync_out <= s3;
    end
  end

endmodule

// *** testbench/mgmt_partner.sv ***
// Purpose: Far-side PHY and embedded PHY data for management reads
// Assumes: MDIO has a pull-up; answers only after the master lets go
// Notes:   Each PHY returns its own fixed word, MSB first
`timescale 1ns/1ps
module mgmt_partner #(
  parameter [15:0] EXT_WORD = 16'ha5c3,
  parameter [15:0] EMB_WORD = 16'h3c5a
) (
  input  wire clk,
  input  wire rstn,
  input  wire mdc,
  input  wire oe,
  output reg  ext_mdio,
  output reg  emb_mdio
);
  reg [6:0] n;
  reg       mdc_q;
  reg       oe_q;
  // Bit index follows MDC falls from the release of MDIO
  always @(posedge clk) begin
    mdc_q <= mdc;
    oe_q  <= oe;
    if (!rstn) begin
      n        <= 7'h40;
      ext_mdio <= 1'b1;
      emb_mdio <= 1'b1;
    end else if (oe_q && !oe) begin
      n        <= 7'h2e;
      ext_mdio <= 1'b1; // Released line sits at the pull-up
      emb_mdio <= 1'b1;
    end else if (mdc_q && !mdc && n < 7'h40) begin
      n        <= n + 7'h1;
      ext_mdio <= (n == 7'h2e) ? 1'b0 :
                  (n < 7'h3f) ? EXT_WORD[7'h3e - n] : 1'b1;
      emb_mdio <= (n == 7'h2e) ? 1'b0 :
                  (n < 7'h3f) ? EMB_WORD[7'h3e - n] : 1'b1;
    end
  end
endmodule

// *** testbench/station_mgmt_asserts.sv ***
// Purpose: Port checks for the station management block
// Assumes: One clock, sync active-low reset
// Notes:   Frame length window allows one clock of slack
`timescale 1ns/1ps
module station_mgmt_asserts (
  input wire       clk,
  input wire       rstn,
  input wire       cmd_start,
  input wire       cmd_busy,
  input wire       cmd_done,
  input wire       mdc_out,
  input wire       mdc_oe,
  input wire       emb_mdc,
  input wire       mac_mode,
  input wire [4:0] secondary_phy_address,
  input wire [4:0] ext_media_addr,
  input wire       datapath_to_ext,
  input wire       sw_iface_sel,
  input wire       rmii_ref_clock_out_oe,
  input wire       ref_clock_direction_flag
);
  reg [10:0] busy_cnt;
  // Busy length; a frame is always 64 MDC bits
  always @(posedge clk) begin
    if (!rstn) busy_cnt <= 11'h0;
    else busy_cnt <= cmd_busy ? busy_cnt + 11'h1 : 11'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_busy_start: assert property (
    cmd_start && !cmd_busy && mac_mode && mdc_oe |=> cmd_busy)
    else $error("busy missing after start");
  chk_frame_len: assert property (
    cmd_done && mac_mode |-> busy_cnt >= 11'h4ff && busy_cnt <= 11'h501)
    else $error("frame length wrong");
  chk_mdc_half: assert property (
    $rose(mdc_out) |-> mdc_out[*8] ##3 !mdc_out)
    else $error("mdc half period wrong");
  chk_mdc_owner: assert property (!mac_mode |-> !mdc_oe)
    else $error("mdc driven in phy role");
  chk_addr_mac: assert property (
    mdc_oe ##1 mdc_oe |-> ext_media_addr == secondary_phy_address)
    else $error("mac role address wrong");
  chk_addr_phy: assert property (!mac_mode ##1 !mac_mode |->
    ext_media_addr == {secondary_phy_address[4:1], 1'b0})
    else $error("phy role address wrong");
  chk_path_sel: assert property ($rose(datapath_to_ext) |->
    $past(sw_iface_sel) && $past(mac_mode))
    else $error("datapath routed without select");
  chk_ref_dir: assert property (
    rmii_ref_clock_out_oe |-> $past(ref_clock_direction_flag))
    else $error("ref clock driven without flag");
  chk_phy_echo: assert property (
    !mac_mode && cmd_start |=> cmd_done && !cmd_busy)
    else $error("phy role command not echoed");
  chk_emb_clock: assert property (
    mac_mode && $past(mac_mode) |-> emb_mdc == $past(mdc_out))
    else $error("embedded mdc not following");
endmodule
bind station_mgmt_phy_select station_mgmt_asserts u_chk (
  .clk(clk), .rstn(rstn), .cmd_start(cmd_start), .cmd_busy(cmd_busy),
  .cmd_done(cmd_done), .mdc_out(mdc_out), .mdc_oe(mdc_oe),
  .emb_mdc(emb_mdc),
  .mac_mode(mac_mode), .secondary_phy_address(secondary_phy_address),
  .ext_media_addr(ext_media_addr), .datapath_to_ext(datapath_to_ext),
  .sw_iface_sel(sw_iface_sel),
  .rmii_ref_clock_out_oe(rmii_ref_clock_out_oe),
  .ref_clock_direction_flag(ref_clock_direction_flag));

// *** testbench/station_mgmt_phy_select_tb.sv ***
// Purpose: Scenario bench for the station management block
// Assumes: External interface strap tied present
// Notes:   MAC role first, then a reset into the PHY role
`timescale 1ns/1ps
module station_mgmt_phy_select_tb;
  reg         clk, rstn, phy_n, sw_sel, ref_flag, link_up;
  reg         cmd_start, cmd_read, mac_mdc, mac_mdio;
  reg  [4:0]  cphy, creg;
  reg  [15:0] cwd, rd;
  reg  [63:0] frame;
  integer     n_fail, n_tests;
  wire        busy, done, mdc_out, mdc_oe, mdio_out, mdio_oe;
  wire        ext_mdio, emb_out, mac_mode, to_ext, ref_oe;
  wire [15:0] rdata;
  wire [4:0]  ext_addr;
  // Shared MDIO wire: device when enabled, else the far side
  wire mdio_line = mdio_oe ? mdio_out : (mac_mode ? ext_mdio : mac_mdio);
  station_mgmt_phy_select dut (.clk(clk), .rstn(rstn),
    .strap_rmii_n(1'b0), .strap_phy_n(phy_n),
    .secondary_phy_address(5'h13), .sw_iface_sel(sw_sel),
    .ref_clock_direction_flag(ref_flag), .link_up(link_up),
    .cmd_start(cmd_start), .cmd_read(cmd_read), .cmd_phy_addr(cphy),
    .cmd_reg_addr(creg), .cmd_wdata(cwd), .cmd_busy(busy),
    .cmd_done(done), .cmd_rdata(rdata), .mdc_in(mac_mdc),
    .mdc_out(mdc_out), .mdc_oe(mdc_oe), .mdio_in(mdio_line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .emb_mdc(),
    .emb_mdio_in(), .emb_mdio_out(emb_out), .mac_mode(mac_mode),
    .datapath_to_ext(to_ext), .rmii_ref_clock_out_oe(ref_oe),
    .ext_media_addr(ext_addr));
  mgmt_partner far (.clk(clk), .rstn(rstn), .mdc(mdc_out),
    .oe(mdio_oe), .ext_mdio(ext_mdio), .emb_mdio(emb_out));
  // Last 64 MDC rises are the most recent frame
  always @(posedge mdc_out) frame <= {frame[62:0], mdio_out};
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task tick(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task check(input [63:0] got, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // One whole frame; a hang is left to the watchdog
  task mgmt(input r, input [4:0] a, input [4:0] g, input [15:0] w);
    begin
      tick(1);
      cmd_start <= 1'b1;
      cmd_read <= r;
      cphy <= a;
      creg <= g;
      cwd <= w;
      tick(1);
      cmd_start <= 1'b0;
      while (done !== 1'b1) tick(1);
    end
  endtask
  task phy_read(input [4:0] a, input [4:0] g);
    reg [63:0] b;
    integer    k;
    begin
      b = {32'hffffffff, 4'b0110, a, g, 18'h3ffff};
      for (k = 0; k < 64; k = k + 1) begin
        mac_mdc <= 1'b0;
        mac_mdio <= b[63-k];
        tick(10);
        if (k > 47) rd = {rd[14:0], mdio_line};
        mac_mdc <= 1'b1;
        tick(10);
      end
      mac_mdc <= 1'b0;
      // Let the closing fall reach the device before the next frame
      tick(10);
    end
  endtask
  task phy_write(input [4:0] a, input [4:0] g, input [15:0] w);
    reg [63:0] b;
    integer    k;
    begin
      b = {32'hffffffff, 4'b0101, a, g, 2'b10, w};
      for (k = 0; k < 64; k = k + 1) begin
        mac_mdc <= 1'b0;
        mac_mdio <= b[63-k];
        tick(10);
        mac_mdc <= 1'b1;
        tick(10);
      end
      mac_mdc <= 1'b0;
      tick(10);
    end
  endtask
  task t_mac;
    integer s;
    begin
      check(mac_mode, 1);
      check(mdc_oe, 1);
      check(ext_addr, 5'h13);
      for (s = 0; s < 4; s = s + 1) begin
        sw_sel <= s[0];
        ref_flag <= s[1];
        tick(3);
        check(to_ext, s[0]);
        check(ref_oe, s[1]);
      end
      $display("mac straps done");
    end
  endtask
  task t_frames;
    begin
      mgmt(1'b0, 5'h13, 5'h04, 16'hbeef);
      check(frame, {32'hffffffff, 4'b0101, 10'h264, 18'h2beef});
      mgmt(1'b1, 5'h05, 5'h02, 16'h0);
      check(rdata, 16'ha5c3);
      check(frame[63:18], {32'hffffffff, 4'b0110, 10'h0a2});
      mgmt(1'b1, 5'h10, 5'h01, 16'h0);
      check(rdata, 16'h3c5a);
      $display("mac frames done");
    end
  endtask
  task t_phy;
    begin
      rstn <= 1'b0;
      phy_n <= 1'b0;
      tick(8);
      rstn <= 1'b1;
      tick(20);
      check(mac_mode, 0);
      check(mdc_oe, 0);
      check(ext_addr, 5'h12);
      cmd_start <= 1'b1;
      tick(1);
      cmd_start <= 1'b0;
      tick(1);
      check({done, busy}, 2'b10);
      link_up <= 1'b1;
      phy_read(5'h12, 5'h01);
      check(rd, 16'h780d);
      phy_read(5'h05, 5'h01);
      check(rd, 16'hffff);
      phy_write(5'h12, 5'h00, 16'h1200);
      phy_read(5'h12, 5'h00);
      check(rd, 16'h1200);
      $display("phy role done");
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    summarize;
  end
  initial begin
    n_fail = 0;
    n_tests = 0;
    {rstn, sw_sel, ref_flag, link_up, cmd_start, cmd_read} = 6'h0;
    {phy_n, mac_mdc, mac_mdio} = 3'h5;
    {cphy, creg, cwd} = 26'h0;
    tick(8);
    rstn <= 1'b1;
    tick(20);
    t_mac;
    t_frames;
    t_phy;
    summarize;
  end
endmodule
